/* hw/peb_pkg.sv */
// Contract
// - Append a sanitize-start record whenever a sanitize operation begins; a start seen while one is still pending is dropped and flags overrun.
// - Sanitize-start record header carries type 09h, revision 01h.
// - Sanitize-start payload: capabilities bytes 3:0, dword ten 7:4, dword eleven 11:8.
// - Append a sanitize-completion record whenever a sanitize operation finishes; one seen while one is still pending is dropped and flags overrun.
// - Sanitize-completion record header carries type 0Ah, revision 01h.
// - Completion payload: progress 1:0, status 3:2, vendor code 5:4, reserved 7:6.
// - Set-features record header carries type 0Bh, revision 01h.
// - Log set-features on success, loggable identifier and an actual setting change.
// - Optionally log successful loggable set-features even when the setting is unchanged.
// - Layout bits 31:16 hold buffer byte count; zero means no buffer field.
// - Layout bits 15:4 reserved; one flag marks completion dword 0 appended.
// - Layout bits 2:0 count dwords from dword ten; values 0 and 7 unused.
// - Command dwords start at payload byte 4, four bytes each, normal order.
// - Buffer bytes follow the command dwords directly; omitted when count is zero.
// - Completion dword 0 follows the buffer when flagged, otherwise nothing appended.
// - Command dwords and buffer bytes are copied unchanged.
package peb_pkg;

    localparam logic [7:0]  TYPE_SAN_START = 8'h09;
    localparam logic [7:0]  TYPE_SAN_DONE  = 8'h0A;
    localparam logic [7:0]  TYPE_SET_FEAT  = 8'h0B;
    localparam logic [7:0]  TYPE_REV       = 8'h01;

    localparam logic [15:0] LEN_SAN_START  = 16'h000C;
    localparam logic [15:0] LEN_SAN_DONE   = 16'h0008;
    localparam logic [15:0] LEN_LAYOUT     = 16'h0004;
    localparam logic [15:0] LEN_CPL        = 16'h0004;
    localparam logic [15:0] IDX_DONE_RESV  = 16'h0006;

    localparam logic [2:0]  DW_LO_BAD      = 3'h0;
    localparam logic [2:0]  DW_HI_BAD      = 3'h7;
    localparam logic [2:0]  DW_MIN         = 3'h1;
    localparam logic [2:0]  DW_MAX         = 3'h6;
    localparam int          DW_SLOTS       = 6;

    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_IRQ_EN     = 8'h08;
    localparam logic [7:0]  REG_IRQ_CLR    = 8'h0C;
    localparam logic [7:0]  REG_FID_LOG    = 8'h10;

    localparam int          EV_START       = 0;
    localparam int          EV_DONE        = 1;
    localparam int          EV_SF          = 2;
    localparam int          EV_OVR         = 3;
    localparam int          NEV            = 4;
    localparam int          STAT_BUSY_BIT  = 8;
    localparam int          CTRL_SAME_BIT  = 0;
    localparam int          FID_EN_BIT     = 8;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SST  = 4'b0010,
        S_SDN  = 4'b0100,
        S_SFE  = 4'b1000
    } peb_fsm_t;

    typedef struct packed {
        logic [31:0] command_dword_eleven;
        logic [31:0] command_dword_ten;
        logic [31:0] caps;
    } peb_san_start_t;

    typedef struct packed {
        logic [15:0] resv;
        logic [15:0] info;
        logic [15:0] status;
        logic [15:0] progress;
    } peb_san_done_t;

    typedef struct packed {
        logic [15:0] buf_count;
        logic [11:0] resv;
        logic        cpl_dw0;
        logic [2:0]  dw_count;
    } peb_layout_t;

    typedef struct packed {
        logic [DW_SLOTS-1:0][31:0] cdw;
        peb_layout_t               layout;
        logic [31:0]               cpl;
    } peb_sf_t;

    typedef struct packed {
        logic        valid;
        logic        first;
        logic        last;
        logic [7:0]  typ;
        logic [7:0]  rev;
        logic [15:0] len;
        logic [7:0]  data;
    } peb_out_t;

    typedef struct packed {
        peb_fsm_t       fsm;
        logic [2:0]     pend;
        logic [15:0]    idx;
        logic [15:0]    len;
        peb_san_start_t ss;
        peb_san_done_t  sd;
        peb_sf_t        sf;
        logic           same;
        logic [NEV-1:0] ien;
        logic [NEV-1:0] stat;
        logic [255:0]   logen;
        logic [31:0]    rdata;
        logic           irq;
        peb_out_t       o;
    } peb_state_t;

endpackage

/* hw/peb_record_builder.sv */
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module peb_record_builder #(
    parameter int BUF_BYTES = 256
) (
    // Clock and reset
    input  wire logic                   CLOCK,
    input  wire logic                   RST_B,
    input  wire logic                   CE,
    // Register port
    input  wire logic [7:0]             REG_ADDR,
    input  wire logic [31:0]            REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output logic [31:0]                 REG_RDATA,
    output logic                        IRQ,
    // Sanitize start
    input  wire logic                   SAN_START,
    input  wire logic [31:0]            SAN_CAPS,
    input  wire logic [31:0]            SAN_COMMAND_DWORD_TEN,
    input  wire logic [31:0]            SAN_COMMAND_DWORD_ELEVEN,
    // Sanitize completion
    input  wire logic                   SAN_DONE,
    input  wire logic [15:0]            SAN_PROG,
    input  wire logic [15:0]            SAN_STAT,
    input  wire logic [15:0]            SAN_INFO,
    // Set-features completion
    input  wire logic                   SF_DONE,
    input  wire logic                   SF_OK,
    input  wire logic [7:0]             SF_FID,
    input  wire logic                   SF_CHANGED,
    input  wire logic [5:0][31:0]       SF_CDW,
    input  wire logic [2:0]             SF_DW_COUNT,
    input  wire logic [15:0]            SF_BUF_COUNT,
    input  wire logic [31:0]            SF_CPL_DW0,
    input  wire logic                   SF_LOG_CPL,
    // Memory buffer fill
    input  wire logic                   BUF_WE,
    input  wire logic [$clog2(BUF_BYTES)-1:0] BUF_ADDR,
    input  wire logic [7:0]             BUF_DATA,
    // Record byte stream
    output peb_pkg::peb_out_t           REC,
    input  wire logic                   REC_READY
);

    localparam int          BUF_AW  = $clog2(BUF_BYTES);
    localparam logic [15:0] BUF_MAX = 16'(BUF_BYTES);

    peb_pkg::peb_state_t q;
    peb_pkg::peb_state_t d;

    // Buffer is a plain byte store; it must not be rewritten while a
    // set-features record is still draining, since bytes are read live.
    logic [7:0] mem [BUF_BYTES];

    logic                adv;
    logic [peb_pkg::NEV-1:0] ev;
    logic                acc_sf;
    logic [2:0]          dwn;
    logic [15:0]         bc;
    logic [15:0]         dw_end;
    logic [15:0]         buf_end;
    logic [7:0]          sf_byte;
    logic [7:0]          out_byte;

    function automatic logic [7:0] pick(input logic [191:0] v, input logic [4:0] i);
        pick = v[{i, 3'b000} +: 8];
    endfunction

    always_ff @(posedge CLOCK) begin
        if (CE && BUF_WE) begin
            mem[BUF_ADDR] <= BUF_DATA;
        end
    end

    // Set-features record geometry from the captured layout
    always_comb begin
        dw_end  = peb_pkg::LEN_LAYOUT + {11'h000, q.sf.layout.dw_count, 2'b00};
        buf_end = dw_end + q.sf.layout.buf_count;
        if (q.idx < peb_pkg::LEN_LAYOUT) begin
            sf_byte = pick(192'(q.sf.layout), q.idx[4:0]);
        end else if (q.idx < dw_end) begin
            sf_byte = pick(192'(q.sf.cdw), 5'(q.idx - peb_pkg::LEN_LAYOUT));
        end else if (q.idx < buf_end) begin
            sf_byte = mem[BUF_AW'(q.idx - dw_end)];
        end else begin
            sf_byte = pick(192'(q.sf.cpl), 5'(q.idx - buf_end));
        end
    end

    always_comb begin
        case (q.fsm)
            peb_pkg::S_SST: out_byte = pick(192'(q.ss), q.idx[4:0]);
            peb_pkg::S_SDN: out_byte = pick(192'(q.sd), q.idx[4:0]);
            peb_pkg::S_SFE: out_byte = sf_byte;
            default:        out_byte = 8'h00;
        endcase
    end

    always_comb begin
        d      = q;
        ev     = '0;
        adv    = !q.o.valid || REC_READY;
        // A setting left unchanged is logged only when software asks for it
        acc_sf = SF_DONE && SF_OK && q.logen[SF_FID] && (SF_CHANGED || q.same);
        dwn    = SF_DW_COUNT;
        if (SF_DW_COUNT == peb_pkg::DW_LO_BAD) begin
            dwn = peb_pkg::DW_MIN;
        end else if (SF_DW_COUNT == peb_pkg::DW_HI_BAD) begin
            dwn = peb_pkg::DW_MAX;
        end
        bc = (SF_BUF_COUNT > BUF_MAX) ? BUF_MAX : SF_BUF_COUNT;

        // Output stage empties when the sink takes the byte
        if (adv) begin
            d.o.valid = 1'b0;
        end

        // Record emission, one payload byte per accepted cycle
        case (q.fsm)
            peb_pkg::S_IDLE: begin
                d.idx = '0;
                if (q.pend[peb_pkg::EV_START]) begin
                    d.fsm = peb_pkg::S_SST;
                    d.len = peb_pkg::LEN_SAN_START;
                end else if (q.pend[peb_pkg::EV_DONE]) begin
                    d.fsm = peb_pkg::S_SDN;
                    d.len = peb_pkg::LEN_SAN_DONE;
                end else if (q.pend[peb_pkg::EV_SF]) begin
                    d.fsm = peb_pkg::S_SFE;
                    d.len = buf_end + (q.sf.layout.cpl_dw0 ? peb_pkg::LEN_CPL : 16'h0000);
                end
            end
            peb_pkg::S_SST, peb_pkg::S_SDN, peb_pkg::S_SFE: begin
                if (adv) begin
                    d.o.valid = 1'b1;
                    d.o.first = (q.idx == 16'h0000);
                    d.o.last  = (q.idx == q.len - 16'h0001);
                    d.o.len   = q.len;
                    d.o.rev   = peb_pkg::TYPE_REV;
                    d.o.data  = out_byte;
                    d.idx     = q.idx + 16'h0001;
                    case (q.fsm)
                        peb_pkg::S_SST: d.o.typ = peb_pkg::TYPE_SAN_START;
                        peb_pkg::S_SDN: d.o.typ = peb_pkg::TYPE_SAN_DONE;
                        default:        d.o.typ = peb_pkg::TYPE_SET_FEAT;
                    endcase
                    if (q.idx == q.len - 16'h0001) begin
                        d.fsm = peb_pkg::S_IDLE;
                        case (q.fsm)
                            peb_pkg::S_SST: begin
                                d.pend[peb_pkg::EV_START] = 1'b0;
                                ev[peb_pkg::EV_START]     = 1'b1;
                            end
                            peb_pkg::S_SDN: begin
                                d.pend[peb_pkg::EV_DONE] = 1'b0;
                                ev[peb_pkg::EV_DONE]     = 1'b1;
                            end
                            default: begin
                                d.pend[peb_pkg::EV_SF] = 1'b0;
                                ev[peb_pkg::EV_SF]     = 1'b1;
                            end
                        endcase
                    end
                end
            end
            default: begin
                d.fsm = peb_pkg::S_IDLE;
            end
        endcase

        // Capture after the release above, so an event in the closing
        // cycle of its own record is still taken
        if (SAN_START) begin
            if (!d.pend[peb_pkg::EV_START]) begin
                d.pend[peb_pkg::EV_START] = 1'b1;
                d.ss.caps  = SAN_CAPS;
                d.ss.command_dword_ten = SAN_COMMAND_DWORD_TEN;
                d.ss.command_dword_eleven = SAN_COMMAND_DWORD_ELEVEN;
            end else begin
                ev[peb_pkg::EV_OVR] = 1'b1;
            end
        end
        if (SAN_DONE) begin
            if (!d.pend[peb_pkg::EV_DONE]) begin
                d.pend[peb_pkg::EV_DONE] = 1'b1;
                d.sd.progress = SAN_PROG;
                d.sd.status   = SAN_STAT;
                d.sd.info     = SAN_INFO;
                d.sd.resv     = '0;
            end else begin
                ev[peb_pkg::EV_OVR] = 1'b1;
            end
        end
        if (acc_sf) begin
            if (!d.pend[peb_pkg::EV_SF]) begin
                d.pend[peb_pkg::EV_SF]     = 1'b1;
                d.sf.cdw                   = SF_CDW;
                d.sf.layout.buf_count      = bc;
                d.sf.layout.resv           = '0;
                d.sf.layout.cpl_dw0        = SF_LOG_CPL;
                d.sf.layout.dw_count       = dwn;
                d.sf.cpl                   = SF_LOG_CPL ? SF_CPL_DW0 : 32'h00000000;
            end else begin
                ev[peb_pkg::EV_OVR] = 1'b1;
            end
        end

        // Register writes
        if (REG_WR) begin
            case (REG_ADDR)
                peb_pkg::REG_CTRL:    d.same = REG_WDATA[peb_pkg::CTRL_SAME_BIT];
                peb_pkg::REG_IRQ_EN:  d.ien  = REG_WDATA[peb_pkg::NEV-1:0];
                peb_pkg::REG_IRQ_CLR: d.stat = q.stat & ~REG_WDATA[peb_pkg::NEV-1:0];
                peb_pkg::REG_FID_LOG: d.logen[REG_WDATA[7:0]] = REG_WDATA[peb_pkg::FID_EN_BIT];
                default: ;
            endcase
        end
        // A new event beats a clear in the same cycle
        d.stat = d.stat | ev;

        // Register reads, data valid in the next cycle only
        d.rdata = 32'h00000000;
        if (REG_RD) begin
            case (REG_ADDR)
                peb_pkg::REG_CTRL: begin
                    d.rdata[peb_pkg::CTRL_SAME_BIT] = q.same;
                end
                peb_pkg::REG_STATUS: begin
                    d.rdata[peb_pkg::NEV-1:0]         = q.stat;
                    d.rdata[peb_pkg::STAT_BUSY_BIT]   = (q.fsm != peb_pkg::S_IDLE);
                end
                peb_pkg::REG_IRQ_EN: begin
                    d.rdata[peb_pkg::NEV-1:0] = q.ien;
                end
                default: ;
            endcase
        end
        d.irq = |(d.stat & d.ien);
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            q <= '{fsm: peb_pkg::S_IDLE, default: '0};
        end else if (CE) begin
            q <= d;
        end
    end

    assign REC       = q.o;
    assign REG_RDATA = q.rdata;
    assign IRQ       = q.irq;

    a_start_header: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        REC.valid && REC.first && q.fsm == peb_pkg::S_SST
        |-> REC.typ == peb_pkg::TYPE_SAN_START && REC.rev == peb_pkg::TYPE_REV
    ) else $error("sanitize start header wrong");

    a_done_header: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        REC.valid && REC.typ == peb_pkg::TYPE_SAN_DONE
        |-> REC.rev == peb_pkg::TYPE_REV && REC.len == peb_pkg::LEN_SAN_DONE
    ) else $error("sanitize completion header wrong");

    a_sf_header: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SFE
        |=> REC.typ == peb_pkg::TYPE_SET_FEAT && REC.rev == peb_pkg::TYPE_REV
    ) else $error("set-features header wrong");

    a_start_len: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        REC.valid && REC.typ == peb_pkg::TYPE_SAN_START |-> REC.len == peb_pkg::LEN_SAN_START
    ) else $error("sanitize start length wrong");

    a_start_taken: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && SAN_START && !q.pend[peb_pkg::EV_START] |=> q.pend[peb_pkg::EV_START]
    ) else $error("sanitize start lost");

    a_done_taken: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && SAN_DONE && !q.pend[peb_pkg::EV_DONE]
        |=> q.pend[peb_pkg::EV_DONE] && q.sd.progress == $past(SAN_PROG)
    ) else $error("sanitize completion lost");

    a_sf_filter: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && SF_DONE && !(SF_OK && q.logen[SF_FID]) && !q.pend[peb_pkg::EV_SF]
        && !(q.fsm == peb_pkg::S_SFE)
        |=> !q.pend[peb_pkg::EV_SF]
    ) else $error("set-features logged without criteria");

    a_dw_count: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        q.fsm == peb_pkg::S_SFE
        |-> q.sf.layout.dw_count != peb_pkg::DW_LO_BAD && q.sf.layout.dw_count != peb_pkg::DW_HI_BAD
    ) else $error("reserved dword count used");

    a_resv_zero: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SDN && q.idx >= peb_pkg::IDX_DONE_RESV
        |=> REC.data == 8'h00
    ) else $error("reserved completion byte not zero");

    a_sf_length: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        q.fsm == peb_pkg::S_SFE
        |-> q.len == buf_end + (q.sf.layout.cpl_dw0 ? peb_pkg::LEN_CPL : 16'h0000)
    ) else $error("set-features length wrong");

    a_start_first: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SST && q.idx == 16'h0000
        |=> REC.data == $past(q.ss.caps[7:0])
    ) else $error("sanitize start first byte wrong");

    a_done_first: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SDN && q.idx == 16'h0000
        |=> REC.data == $past(q.sd.progress[7:0])
    ) else $error("sanitize completion first byte wrong");

    a_done_type: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SDN
        |=> REC.valid && REC.typ == peb_pkg::TYPE_SAN_DONE
    ) else $error("sanitize completion type wrong");

    a_layout_first: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SFE && q.idx == 16'h0000
        |=> REC.first && REC.data[2:0] == $past(q.sf.layout.dw_count)
    ) else $error("layout dword count byte wrong");

    a_dword_first: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SFE && q.idx == peb_pkg::LEN_LAYOUT
        |=> REC.data == $past(q.sf.cdw[0][7:0])
    ) else $error("first command dword byte wrong");

    a_buffer_first: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SFE && q.idx == dw_end && q.sf.layout.buf_count != 16'h0000
        |=> REC.data == $past(mem[0])
    ) else $error("first buffer byte misplaced");

    a_cpl_first: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && adv && q.fsm == peb_pkg::S_SFE && q.idx == buf_end && q.sf.layout.cpl_dw0
        |=> REC.data == $past(q.sf.cpl[7:0])
    ) else $error("completion dword misplaced");

    a_layout_resv: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        q.pend[peb_pkg::EV_SF]
        |-> q.sf.layout.resv == '0
    ) else $error("reserved layout bits set");

    a_unchanged_skip: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        CE && SF_DONE && SF_OK && !SF_CHANGED && !q.same && !q.pend[peb_pkg::EV_SF]
        |=> !q.pend[peb_pkg::EV_SF]
    ) else $error("unchanged setting logged unasked");

    a_done_resv: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        q.pend[peb_pkg::EV_DONE]
        |-> q.sd.resv == 16'h0000
    ) else $error("reserved completion field set");

endmodule
`default_nettype wire

/* testbench/peb_log_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module peb_log_reader (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Record stream
    input  wire peb_pkg::peb_out_t rec,
    input  wire logic              slow,
    output logic                   ready
);
    logic [7:0]  got_q[$];
    logic [7:0]  typ_q;
    logic [7:0]  rev_q;
    logic [15:0] len_q;
    int          n_rec;
    logic        tick;
    // Slow mode stalls every other cycle, like a host busy with other traffic
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready <= 1'b0;
            tick <= 1'b0;
            n_rec <= 0;
        end else begin
            tick <= !tick;
            ready <= !slow || tick;
            if (rec.valid && ready) begin
                if (rec.first) begin
                    got_q.delete();
                    typ_q <= rec.typ;
                    rev_q <= rec.rev;
                    len_q <= rec.len;
                end
                got_q.push_back(rec.data);
                if (rec.last) begin
                    n_rec <= n_rec + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/test_persistent_event_record_builder.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_persistent_event_record_builder;
    logic CLOCK = 0, RST_B = 0, CE = 1, REG_WR = 0, REG_RD = 0, SAN_START = 0, SAN_DONE = 0;
    logic [7:0] REG_ADDR = 8'h00, SF_FID = 8'h00, BUF_ADDR = 8'h00, BUF_DATA = 8'h00;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, SAN_CAPS = 32'h0, SAN_COMMAND_DWORD_TEN = 32'h0;
    logic [31:0] SAN_COMMAND_DWORD_ELEVEN = 32'h0, SF_CPL_DW0 = 32'h0;
    logic [15:0] SAN_PROG = 16'h0, SAN_STAT = 16'h0, SAN_INFO = 16'h0, SF_BUF_COUNT = 16'h0;
    logic SF_DONE = 0, SF_OK = 0, SF_CHANGED = 0, SF_LOG_CPL = 0, BUF_WE = 0, IRQ, REC_READY;
    logic slow = 0;
    logic [5:0][31:0] SF_CDW = '0;
    logic [2:0] SF_DW_COUNT = 3'h1;
    peb_pkg::peb_out_t REC;
    logic [7:0] exp_q[$];
    logic [31:0] rd;
    int n_fail = 0, samples_checked = 0, cycles = 0;

    always #2.5 CLOCK = !CLOCK;

    peb_record_builder #(.BUF_BYTES(256)) u_peb_record_builder (.CLOCK(CLOCK), .RST_B(RST_B),
        .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .IRQ(IRQ), .SAN_START(SAN_START), .SAN_CAPS(SAN_CAPS),
        .SAN_COMMAND_DWORD_TEN(SAN_COMMAND_DWORD_TEN), .SAN_COMMAND_DWORD_ELEVEN(SAN_COMMAND_DWORD_ELEVEN), .SAN_DONE(SAN_DONE), .SAN_PROG(SAN_PROG),
        .SAN_STAT(SAN_STAT), .SAN_INFO(SAN_INFO), .SF_DONE(SF_DONE), .SF_OK(SF_OK),
        .SF_FID(SF_FID), .SF_CHANGED(SF_CHANGED), .SF_CDW(SF_CDW), .SF_DW_COUNT(SF_DW_COUNT),
        .SF_BUF_COUNT(SF_BUF_COUNT), .SF_CPL_DW0(SF_CPL_DW0), .SF_LOG_CPL(SF_LOG_CPL),
        .BUF_WE(BUF_WE), .BUF_ADDR(BUF_ADDR), .BUF_DATA(BUF_DATA), .REC(REC),
        .REC_READY(REC_READY));

    peb_log_reader u_peb_log_reader (.clk(CLOCK), .rst_b(RST_B), .rec(REC), .slow(slow),
        .ready(REC_READY));

    task automatic close_out();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic reg_rd(input logic [7:0] a);
        @(posedge CLOCK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1 rd = REG_RDATA;
    endtask

    task automatic put(input logic [31:0] w, input int nb);
        for (int i = 0; i < nb; i++) begin
            exp_q.push_back(w[8*i +: 8]);
        end
    endtask

    // Waits for one whole record and compares header codes and every payload byte
    task automatic check_rec(input logic [7:0] typ);
        int n0;
        n0 = u_peb_log_reader.n_rec;
        for (int i = 0; i < 400 && u_peb_log_reader.n_rec == n0; i++) begin
            @(posedge CLOCK);
        end
        #1;
        `CHK("record count", n0 + 1, u_peb_log_reader.n_rec)
        `CHK("type", typ, u_peb_log_reader.typ_q)
        `CHK("revision", 8'h01, u_peb_log_reader.rev_q)
        `CHK("length", exp_q.size(), int'(u_peb_log_reader.len_q))
        `CHK("bytes seen", exp_q.size(), u_peb_log_reader.got_q.size())
        for (int i = 0; i < exp_q.size() && i < u_peb_log_reader.got_q.size(); i++) begin
            `CHK("payload byte", exp_q[i], u_peb_log_reader.got_q[i])
        end
        exp_q.delete();
    endtask

    task automatic t_regs();
        reg_rd(peb_pkg::REG_STATUS);
        `CHK("status after reset", 32'h0, rd)
        reg_rd(8'h40);
        `CHK("unmapped read", 32'h0, rd)
        reg_wr(peb_pkg::REG_IRQ_EN, 32'h0000_000F);
        reg_rd(peb_pkg::REG_IRQ_EN);
        `CHK("irq enable", 32'h0000_000F, rd)
        // A start pulse while the enable is low must leave no trace
        @(posedge CLOCK);
        CE <= 1'b0;
        SAN_START <= 1'b1;
        @(posedge CLOCK);
        CE <= 1'b1;
        SAN_START <= 1'b0;
        repeat (20) @(posedge CLOCK);
        `CHK("frozen start", 0, u_peb_log_reader.n_rec)
    endtask

    task automatic t_start();
        @(posedge CLOCK);
        SAN_START <= 1'b1;
        SAN_CAPS <= 32'h8765_4321;
        SAN_COMMAND_DWORD_TEN <= 32'h1122_3344;
        SAN_COMMAND_DWORD_ELEVEN <= 32'hA5B6_C7D8;
        // Held a second cycle: the repeat finds the event pending and is dropped
        repeat (2) @(posedge CLOCK);
        SAN_START <= 1'b0;
        put(32'h8765_4321, 4);
        put(32'h1122_3344, 4);
        put(32'hA5B6_C7D8, 4);
        check_rec(8'h09);
        reg_rd(peb_pkg::REG_STATUS);
        `CHK("start status bit", 1'b1, rd[0])
        `CHK("overrun bit", 1'b1, rd[3])
        `CHK("irq raised", 1'b1, IRQ)
        reg_wr(peb_pkg::REG_IRQ_CLR, 32'h0000_000F);
        reg_rd(peb_pkg::REG_STATUS);
        `CHK("status cleared", 32'h0, rd)
        `CHK("irq dropped", 1'b0, IRQ)
    endtask

    // Slow host and a masked interrupt
    task automatic t_done();
        slow = 1'b1;
        reg_wr(peb_pkg::REG_IRQ_EN, 32'h0000_0000);
        @(posedge CLOCK);
        SAN_DONE <= 1'b1;
        SAN_PROG <= 16'hFEDC;
        SAN_STAT <= 16'h0123;
        SAN_INFO <= 16'h5AA5;
        @(posedge CLOCK);
        SAN_DONE <= 1'b0;
        put(32'h0123_FEDC, 4);
        put(32'h0000_5AA5, 4);
        check_rec(8'h0A);
        reg_rd(peb_pkg::REG_STATUS);
        `CHK("done status bit", 1'b1, rd[1])
        `CHK("irq masked", 1'b0, IRQ)
        slow = 1'b0;
    endtask

    task automatic sf_go(input logic ok, chg, input logic [2:0] dwc, input logic [15:0] bc,
                         input logic cpl, input logic logged);
        int n0;
        n0 = u_peb_log_reader.n_rec;
        @(posedge CLOCK);
        SF_DONE <= 1'b1;
        SF_OK <= ok;
        SF_FID <= 8'h0C;
        SF_CHANGED <= chg;
        SF_DW_COUNT <= dwc;
        SF_BUF_COUNT <= bc;
        SF_LOG_CPL <= cpl;
        SF_CPL_DW0 <= 32'hC0DE_0001;
        @(posedge CLOCK);
        SF_DONE <= 1'b0;
        if (logged) begin
            put({bc, 12'h000, cpl, dwc}, 4);
            for (int i = 0; i < dwc; i++) begin
                put(SF_CDW[i], 4);
            end
            for (int i = 0; i < bc; i++) begin
                put(32'h50 + i, 1);
            end
            if (cpl) begin
                put(32'hC0DE_0001, 4);
            end
            check_rec(8'h0B);
        end else begin
            repeat (30) @(posedge CLOCK);
            `CHK("no record", n0, u_peb_log_reader.n_rec)
        end
    endtask

    task automatic t_set_features();
        @(posedge CLOCK);
        for (int i = 0; i < 6; i++) begin
            SF_CDW[i] <= 32'hA000_0000 + i * 32'h0101_0101;
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge CLOCK);
            BUF_WE <= 1'b1;
            BUF_ADDR <= i[7:0];
            BUF_DATA <= 8'h50 + i[7:0];
        end
        @(posedge CLOCK);
        BUF_WE <= 1'b0;
        sf_go(1'b1, 1'b1, 3'h1, 16'h0, 1'b0, 1'b0);
        reg_wr(peb_pkg::REG_FID_LOG, 32'h0000_010C);
        sf_go(1'b0, 1'b1, 3'h1, 16'h0, 1'b0, 1'b0);
        sf_go(1'b1, 1'b0, 3'h1, 16'h0, 1'b0, 1'b0);
        sf_go(1'b1, 1'b1, 3'h6, 16'h0, 1'b0, 1'b1);
        sf_go(1'b1, 1'b1, 3'h1, 16'h3, 1'b1, 1'b1);
        reg_wr(peb_pkg::REG_CTRL, 32'h0000_0001);
        sf_go(1'b1, 1'b0, 3'h2, 16'h4, 1'b0, 1'b1);
    endtask

    initial begin
        repeat (3) @(posedge CLOCK);
        RST_B <= 1'b1;
        t_regs();
        t_start();
        t_done();
        t_set_features();
        close_out();
    end
endmodule
`default_nettype wire
